//--- dswp_serial_port.sv
// dswp_serial_port: single wire half duplex debug serial port
// assumes an external pull-up on the pin and one system clock domain
//
// How it works
// - debugger enabled after every reset
// - enable clear ignored while lock bit set
// - open-drain half duplex, never both directions
// - start, 8 or 9 data LSB first, stop
// - transmit low start, data, high stop bits; under flow control the far side drives the start
// - sample start at half bit, reject high
// - data sampled at centre, one bit apart
// - stop sampled at centre, low means framing error
// - hunt next start right after stop sample
// - reload equals clocks per eight bits
// - 16-bit reload, 12 bits while enabled
// - fastest rate eight clocks per bit
// - autobaud 80h, 0Dh only when disabled
// - 80h: start fall to bit 7 rise
// - 0Dh: start end rise to stop rise
// - measured count loaded as reload value
// - output enable drives high and low
// - both bits: one clock high pulse
// - drive high until line high or mid-bit
// - high drive bit selects strong pin driver
// - nine-bit mode adds bit after bit seven
// - flow control: wait for receiver's start bit
`timescale 1ns/100ps
module dswp_serial_port
   import dswp_pkg::*;
(
   input  wire logic        clock,        // system clock, 25 MHz
   input  wire logic        srst,         // synchronous reset, active high
   input  wire logic [7:0]  reg_addr,     // register address
   input  wire logic [15:0] reg_wdata,    // register write data
   input  wire logic        reg_wr,       // write strobe
   input  wire logic        reg_rd,       // read strobe
   output logic      [15:0] reg_rdata,    // read data, cycle after strobe
   input  wire logic        pin_i,        // debug serial pin level
   output logic             pin_o,        // debug serial pin drive value
   output logic             pin_oe,       // debug serial pin drive enable
   output logic             pin_hi_drive, // selects strong output driver
   output logic             dbg_enable    // debugger enable bit
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // bit period in clocks from the reload value
   function automatic logic [15:0] bit_len(input logic [15:0] rld, input logic en);
      logic [15:0] eff;
      logic [15:0] b;
      eff = en ? (rld & RELOAD_EN_MASK) : rld;
      b   = eff >> RELOAD_SHIFT;
      // a reload below eight would give a zero period; clamp to one clock
      // so the counters still advance; rates above clock/8 are the user's risk
      // because the three stage pin sampler eats most of a short bit
      if (b == 16'h0000) begin
         b = 16'h0001;
      end
      return b;
   endfunction : bit_len

   // half bit period, never zero
   function automatic logic [15:0] half_len(input logic [15:0] b);
      logic [15:0] h;
      h = b >> 1;
      if (h == 16'h0000) begin
         h = 16'h0001;
      end
      return h;
   endfunction : half_len

   dswp_state_type st_ff;
   dswp_state_type nxt_st;

   logic [15:0] bitp;
   logic [15:0] halfp;
   logic        fall;
   logic        rise;
   logic        alt_sel;
   logic [3:0]  nbits;
   logic        tx_act;
   logic        tx_bit_end;

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks on the timing constants
   if (RELOAD_SHIFT < 1 || RELOAD_SHIFT > 15) begin : g_bad_shift
      $error("reload shift out of range");
   end
   if (RELOAD_EN_MASK == 16'h0000) begin : g_bad_mask
      $error("reload mask is empty");
   end
   if (BITS_NINE != BITS_EIGHT + 4'h1) begin : g_bad_bits
      $error("ninth bit count is wrong");
   end

   ////////////////////////////////////////////////////////////////////////////
   // derived terms
   // edges are taken from the filtered line, so every edge
   // the state machines see is four clocks behind the pin
   always_comb begin
      bitp    = bit_len(st_ff.reload, st_ff.ctrl.enable);
      halfp   = half_len(bitp);
      fall    = st_ff.line_prev & ~st_ff.line;
      rise    = ~st_ff.line_prev & st_ff.line;
      alt_sel = st_ff.ctrl.alt_char & ~st_ff.ctrl.enable;
      nbits   = st_ff.ctrl.nine ? BITS_NINE : BITS_EIGHT;
      tx_act  = (st_ff.tx_st != TX_IDLE);
      tx_bit_end = (st_ff.tx_cnt == bitp - 16'h0001);
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      nxt_st = st_ff;

      // pin sampling: change counts once second and third stages agree
      // the pin is asynchronous; a pulse shorter than one
      // clock never reaches the line state
      nxt_st.sync = {st_ff.sync[1:0], pin_i};
      if (st_ff.sync[1] == st_ff.sync[2]) begin
         nxt_st.line = st_ff.sync[2];
      end
      nxt_st.line_prev = st_ff.line;

      // register reads: data stands in the following cycle only
      // idle cycles return zero so a wired-or read bus stays clean
      nxt_st.rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL:   nxt_st.rdata = {7'h00, st_ff.ctrl};
            REG_RELOAD: nxt_st.rdata = st_ff.reload;
            REG_RXDATA: nxt_st.rdata = {7'h00, st_ff.rx_data};
            REG_STATUS: nxt_st.rdata = {10'h000, (st_ff.ab_st != AB_IDLE), st_ff.ab_done,
                                        st_ff.frame_err, st_ff.rx_valid,
                                        (st_ff.rx_st != RX_IDLE), tx_act};
            default:    nxt_st.rdata = 16'h0000;
         endcase
         if (reg_addr == REG_RXDATA) begin
            nxt_st.rx_valid = 1'b0;
         end
      end

      // register writes
      // lock is set-only; enable obeys the write only while unlocked
      if (reg_wr) begin
         case (reg_addr)
            REG_CTRL: begin
               nxt_st.ctrl = reg_wdata[8:0];
               nxt_st.ctrl.enable = st_ff.ctrl.lock ? st_ff.ctrl.enable : reg_wdata[CTL_ENABLE];
               nxt_st.ctrl.lock   = st_ff.ctrl.lock | reg_wdata[CTL_LOCK];
            end
            REG_RELOAD: nxt_st.reload = reg_wdata;
            REG_STATUS: begin
               if (reg_wdata[STA_FRERR]) begin
                  nxt_st.frame_err = 1'b0;
               end
               if (reg_wdata[STA_ABDONE]) begin
                  nxt_st.ab_done = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // auto-baud measurement, receiver held off while armed
      // the count runs one per clock, so it is clocks per
      // eight bits directly and loads the reload unchanged
      case (st_ff.ab_st)
         // wait for the first falling edge while armed
         AB_IDLE: begin
            if (st_ff.ctrl.ab_arm && !tx_act && fall) begin
               nxt_st.ab_cnt   = 16'h0001;
               nxt_st.ab_rises = 2'h0;
               nxt_st.ab_st    = alt_sel ? AB_FIRST : AB_MEAS;
            end
         end
         // alternative character: start counting at the first rise
         AB_FIRST: begin
            if (rise) begin
               nxt_st.ab_cnt   = 16'h0001;
               nxt_st.ab_rises = 2'h1;
               nxt_st.ab_st    = AB_MEAS;
            end
         end
         // count clocks until the closing rise
         AB_MEAS: begin
            nxt_st.ab_cnt = st_ff.ab_cnt + 16'h0001;
            if (rise) begin
               nxt_st.ab_rises = st_ff.ab_rises + 2'h1;
               if (!alt_sel || (st_ff.ab_rises + 2'h1 == AB_RISES_ALT)) begin
                  nxt_st.reload      = st_ff.ab_cnt;
                  nxt_st.ctrl.ab_arm = 1'b0;
                  nxt_st.ab_done     = 1'b1;
                  nxt_st.ab_st       = AB_IDLE;
               end
            end
         end
         default: nxt_st.ab_st = AB_IDLE;
      endcase

      // receiver, idle while transmitting or measuring
      // our own start bit would otherwise be heard as
      // an incoming character on the shared wire
      nxt_st.rx_cnt = st_ff.rx_cnt + 16'h0001;
      case (st_ff.rx_st)
         // hunt for a falling edge
         RX_IDLE: begin
            if (fall && !tx_act && !st_ff.ctrl.ab_arm && st_ff.ab_st == AB_IDLE) begin
               nxt_st.rx_cnt = 16'h0001;
               nxt_st.rx_st  = RX_HALF;
            end
         end
         // confirm the start bit at its centre
         RX_HALF: begin
            if (st_ff.rx_cnt >= halfp) begin
               nxt_st.rx_cnt = 16'h0001;
               nxt_st.rx_idx = 4'h0;
               nxt_st.rx_st  = st_ff.line ? RX_IDLE : RX_DATA;
            end
         end
         // shift in data bits from the top, lsb first
         RX_DATA: begin
            if (st_ff.rx_cnt >= bitp) begin
               nxt_st.rx_cnt   = 16'h0001;
               nxt_st.rx_shift = {st_ff.line, st_ff.rx_shift[8:1]};
               nxt_st.rx_idx   = st_ff.rx_idx + 4'h1;
               if (st_ff.rx_idx + 4'h1 == nbits) begin
                  nxt_st.rx_st = RX_STOP;
               end
            end
         end
         // stop bit centre: hand over and check framing
         RX_STOP: begin
            if (st_ff.rx_cnt >= bitp) begin
               nxt_st.rx_data   = st_ff.ctrl.nine ? st_ff.rx_shift : {1'b0, st_ff.rx_shift[8:1]};
               nxt_st.rx_valid  = 1'b1;
               if (!st_ff.line) begin
                  nxt_st.frame_err = 1'b1;
               end
               nxt_st.rx_st     = RX_IDLE;
            end
         end
         default: nxt_st.rx_st = RX_IDLE;
      endcase

      // transmitter
      // a write to the data register is dropped while any
      // other traffic owns the wire; software polls busy
      nxt_st.tx_cnt = st_ff.tx_cnt + 16'h0001;
      case (st_ff.tx_st)
         // accept a character only when the wire is free
         TX_IDLE: begin
            if (reg_wr && reg_addr == REG_TXDATA && st_ff.rx_st == RX_IDLE
                && st_ff.ab_st == AB_IDLE) begin
               nxt_st.tx_shift = reg_wdata[8:0];
               nxt_st.tx_idx   = 4'h0;
               nxt_st.tx_cnt   = 16'h0000;
               nxt_st.tx_bit   = 1'b0;
               nxt_st.tx_st    = st_ff.ctrl.flow ? TX_WAIT : TX_START;
            end
         end
         // flow control: hold until the far side sends a start
         TX_WAIT: begin
            nxt_st.tx_bit = 1'b1;
            if (fall) begin
               nxt_st.tx_cnt = 16'h0002;
               nxt_st.tx_st  = TX_START;
            end
         end
         // start bit, low for one period
         TX_START: begin
            if (tx_bit_end) begin
               nxt_st.tx_cnt   = 16'h0000;
               nxt_st.tx_bit   = st_ff.tx_shift[0];
               nxt_st.tx_shift = {1'b0, st_ff.tx_shift[8:1]};
               nxt_st.tx_idx   = 4'h1;
               nxt_st.tx_st    = TX_DATA;
            end
         end
         // data bits lsb first, ninth bit last
         TX_DATA: begin
            if (tx_bit_end) begin
               nxt_st.tx_cnt = 16'h0000;
               if (st_ff.tx_idx == nbits) begin
                  nxt_st.tx_bit = 1'b1;
                  nxt_st.tx_st  = TX_STOP;
               end else begin
                  nxt_st.tx_bit   = st_ff.tx_shift[0];
                  nxt_st.tx_shift = {1'b0, st_ff.tx_shift[8:1]};
                  nxt_st.tx_idx   = st_ff.tx_idx + 4'h1;
               end
            end
         end
         // stop bit, high for one period; driven only in the assist modes
         TX_STOP: begin
            if (tx_bit_end) begin
               nxt_st.tx_st = TX_IDLE;
            end
         end
         default: nxt_st.tx_st = TX_IDLE;
      endcase

      // drive-high assist: set at start of each one bit, ended per mode
      // it speeds the rising edge on a loaded wire; releasing
      // early keeps the open-drain sharing safe
      if (nxt_st.tx_st != st_ff.tx_st || nxt_st.tx_cnt == 16'h0000) begin
         nxt_st.tx_hi = nxt_st.tx_bit & st_ff.ctrl.drv_high;
      end else if (st_ff.ctrl.out_en) begin
         nxt_st.tx_hi = 1'b0;
      end else if (st_ff.line || st_ff.tx_cnt >= halfp) begin
         nxt_st.tx_hi = 1'b0;
      end

      // pin drive
      // zeros are pulled low except the start bit under flow control; ones rely on the pull-up
      // unless one of the assist modes drives them
      nxt_st.pin_o  = 1'b0;
      nxt_st.pin_oe = 1'b0;
      if (nxt_st.tx_st != TX_IDLE && nxt_st.tx_st != TX_WAIT) begin
         if (!nxt_st.tx_bit) begin
            nxt_st.pin_oe = !(nxt_st.tx_st == TX_START && st_ff.ctrl.flow);
         end else if (st_ff.ctrl.out_en && !st_ff.ctrl.drv_high) begin
            nxt_st.pin_o  = 1'b1;
            nxt_st.pin_oe = 1'b1;
         end else if (nxt_st.tx_hi) begin
            nxt_st.pin_o  = 1'b1;
            nxt_st.pin_oe = 1'b1;
         end
      end

      // hardware set wins over a software clear in the same cycle
      if (st_ff.rx_st == RX_STOP && st_ff.rx_cnt >= bitp) begin
         nxt_st.rx_valid = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   // reset leaves the debugger enabled and auto-baud armed
   // so a host can connect without software help
   always_ff @(posedge clock) begin
      if (srst) begin
         st_ff             <= '0;
         st_ff.ctrl.enable <= RST_ENABLE;
         st_ff.ctrl.ab_arm <= RST_ABARM;
         st_ff.reload      <= RST_RELOAD;
         st_ff.sync        <= 3'h7;
         st_ff.line        <= 1'b1;
         st_ff.line_prev   <= 1'b1;
         st_ff.rx_st       <= RX_IDLE;
         st_ff.tx_st       <= TX_IDLE;
         st_ff.ab_st       <= AB_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // all outputs come straight from the state register
   assign reg_rdata    = st_ff.rdata;
   assign pin_o        = st_ff.pin_o;
   assign pin_oe       = st_ff.pin_oe;
   assign pin_hi_drive = st_ff.ctrl.hi_drive;
   assign dbg_enable   = st_ff.ctrl.enable;

endmodule : dswp_serial_port

//--- dswp_pkg.sv
// dswp_pkg: constants and types for the single wire debug serial port
// assumes a single system clock domain and a plain register port
package dswp_pkg;
   // register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_RELOAD = 8'h01;
   localparam logic [7:0] REG_TXDATA = 8'h02;
   localparam logic [7:0] REG_RXDATA = 8'h03;
   localparam logic [7:0] REG_STATUS = 8'h04;
   // control register bit positions
   localparam int CTL_ENABLE  = 0;
   localparam int CTL_LOCK    = 1;
   localparam int CTL_ALTCHAR = 2;
   localparam int CTL_OUTEN   = 3;
   localparam int CTL_DRVHIGH = 4;
   localparam int CTL_HIDRIVE = 5;
   localparam int CTL_NINE    = 6;
   localparam int CTL_FLOW    = 7;
   localparam int CTL_ABARM   = 8;
   // status register bit positions
   localparam int STA_TXBUSY  = 0;
   localparam int STA_RXBUSY  = 1;
   localparam int STA_RXVALID = 2;
   localparam int STA_FRERR   = 3;
   localparam int STA_ABDONE  = 4;
   localparam int STA_ABBUSY  = 5;
   // values after reset
   localparam logic [15:0] RST_RELOAD  = 16'h0040;
   localparam logic        RST_ENABLE  = 1'b1;
   localparam logic        RST_ABARM   = 1'b1;
   // timing: bits per reload, mask applied while enabled
   localparam int          RELOAD_SHIFT   = 3;
   localparam logic [15:0] RELOAD_EN_MASK = 16'h0fff;
   localparam logic [3:0]  BITS_EIGHT     = 4'h8;
   localparam logic [3:0]  BITS_NINE      = 4'h9;
   localparam logic [1:0]  AB_RISES_ALT   = 2'h3;

   typedef enum logic [2:0] {RX_IDLE, RX_HALF, RX_DATA, RX_STOP} dswp_rx_type;
   typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_STOP} dswp_tx_type;
   typedef enum logic [1:0] {AB_IDLE, AB_FIRST, AB_MEAS} dswp_ab_type;

   // control bits grouped
   typedef struct packed {
      logic ab_arm;
      logic flow;
      logic nine;
      logic hi_drive;
      logic drv_high;
      logic out_en;
      logic alt_char;
      logic lock;
      logic enable;
   } dswp_ctrl_type;

   // whole module state
   typedef struct packed {
      dswp_ctrl_type ctrl;
      logic [15:0]   reload;
      logic [2:0]    sync;
      logic          line;
      logic          line_prev;
      dswp_rx_type   rx_st;
      logic [15:0]   rx_cnt;
      logic [3:0]    rx_idx;
      logic [8:0]    rx_shift;
      logic [8:0]    rx_data;
      logic          rx_valid;
      logic          frame_err;
      dswp_tx_type   tx_st;
      logic [15:0]   tx_cnt;
      logic [3:0]    tx_idx;
      logic [8:0]    tx_shift;
      logic          tx_bit;
      logic          tx_hi;
      dswp_ab_type   ab_st;
      logic [15:0]   ab_cnt;
      logic [1:0]    ab_rises;
      logic          ab_done;
      logic          pin_o;
      logic          pin_oe;
      logic [15:0]   rdata;
   } dswp_state_type;
endpackage : dswp_pkg

//--- dswp_checker.sv
// dswp_checker: port level assertions for the debug serial port
// assumes binding to dswp_serial_port, one clock domain, pin modes set by ctrl writes
`timescale 1ns/100ps
module dswp_checker
   import dswp_pkg::*;
(
   input wire logic        clock,        // system clock
   input wire logic        srst,         // synchronous reset
   input wire logic [7:0]  reg_addr,     // register address
   input wire logic [15:0] reg_wdata,    // register write data
   input wire logic        reg_wr,       // write strobe
   input wire logic        reg_rd,       // read strobe
   input wire logic [15:0] reg_rdata,    // read data
   input wire logic        pin_i,        // pin level
   input wire logic        pin_o,        // pin drive value
   input wire logic        pin_oe,       // pin drive enable
   input wire logic        pin_hi_drive, // strong driver select
   input wire logic        dbg_enable    // debugger enable
);
   logic ctl_wr;
   logic lock_ff;
   logic oen_ff;
   logic dh_ff;
   logic drv_hi;
   assign ctl_wr = reg_wr && (reg_addr == REG_CTRL);
   assign drv_hi = pin_oe && pin_o;
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of the lock bit and the control bits that shape the pin drive
   always_ff @(posedge clock) begin
      if (srst) begin
         lock_ff <= 1'b0;
         oen_ff  <= 1'b0;
         dh_ff   <= 1'b0;
      end else if (ctl_wr) begin
         lock_ff <= lock_ff | reg_wdata[CTL_LOCK];
         oen_ff  <= reg_wdata[CTL_OUTEN];
         dh_ff   <= reg_wdata[CTL_DRVHIGH];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////////
   chk_reset_state: assert property (disable iff (1'b0) srst |=> dbg_enable && !pin_oe && reg_rdata == 16'h0000)
      else $error("state after reset wrong");
   chk_lock_holds: assert property (lock_ff && dbg_enable |=> dbg_enable)
      else $error("debugger disabled while locked");
   chk_enable_clear: assert property (ctl_wr && !reg_wdata[CTL_ENABLE] && !reg_wdata[CTL_LOCK] && !lock_ff |=> !dbg_enable)
      else $error("enable clear not taken");
   chk_hi_drive: assert property (ctl_wr |=> pin_hi_drive == $past(reg_wdata[CTL_HIDRIVE]))
      else $error("high drive bit not followed");
   chk_open_drain: assert property (!oen_ff && !dh_ff && pin_oe |-> !pin_o)
      else $error("pin driven high in open drain mode");
   chk_out_en_high: assert property ($rose(drv_hi) && oen_ff && !dh_ff |=> drv_hi [*6])
      else $error("one not driven for the whole bit");
   chk_one_pulse: assert property (oen_ff && dh_ff && drv_hi |=> !drv_hi)
      else $error("high pulse longer than one clock");
   chk_drive_release: assert property ((!oen_ff && dh_ff && drv_hi) [*6] |=> !drv_hi)
      else $error("high drive not released");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   cov_tx: cover property ($rose(pin_oe));
   cov_disable: cover property ($fell(dbg_enable));
   cov_pulse: cover property (oen_ff && dh_ff && drv_hi);
endmodule : dswp_checker

bind dswp_serial_port dswp_checker u_chk (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
   .pin_hi_drive(pin_hi_drive), .dbg_enable(dbg_enable));

//--- dswp_host.sv
// dswp_host: behavioural host debugger on the single wire
// assumes the bench resolves the wire with a pull-up; host only pulls low
`timescale 1ns/100ps
module dswp_host (
   input  wire logic       clock,     // system clock
   input  wire logic       line,      // resolved wire level
   output logic            drive_low, // host pulls the wire low
   output logic [8:0]      got,       // last character heard
   output logic            got_stb    // one clock pulse per character
);
   int         bitp    = 8;
   int         nbits   = 8;
   logic       sending = 1'b0;
   logic [8:0] r       = 9'h000;
   initial begin
      drive_low = 1'b0;
      got       = 9'h000;
      got_stb   = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // send one character: start, data lsb first, stop of chosen level and length
   task automatic send(input logic [8:0] dat, input logic stop_v, input int stop_len);
      sending = 1'b1;
      @(posedge clock);
      drive_low <= 1'b1;
      repeat (bitp) @(posedge clock);
      for (int i = 0; i < nbits; i++) begin
         drive_low <= !dat[i];
         repeat (bitp) @(posedge clock);
      end
      drive_low <= !stop_v;
      repeat (stop_len) @(posedge clock);
      drive_low <= 1'b0;
      sending = 1'b0;
   endtask : send
   // short low pulse that is gone before mid bit
   task automatic glitch();
      sending = 1'b1;
      @(posedge clock);
      drive_low <= 1'b1;
      repeat (3) @(posedge clock);
      drive_low <= 1'b0;
      sending = 1'b0;
   endtask : glitch
   // receive: sample at bit centres after a falling edge
   always begin
      @(negedge line);
      if (!sending) begin
         repeat (bitp / 2) @(posedge clock);
         if (!line) begin
            for (int i = 0; i < nbits; i++) begin
               repeat (bitp) @(posedge clock);
               r[i] = line;
            end
            repeat (bitp) @(posedge clock);
            got     <= line ? r : 9'h1ff;
            got_stb <= 1'b1;
            @(posedge clock);
            got_stb <= 1'b0;
            r = 9'h000;
         end
      end
   end
endmodule : dswp_host

//--- dswp_serial_port_tb.sv
// dswp_serial_port_tb: self-checking bench for the debug serial port
// assumes the host model on the wire and a pull-up resolving released states
`timescale 1ns/100ps
module dswp_serial_port_tb;
   import dswp_pkg::*;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rd_q = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic        pin_o, pin_oe, pin_hi_drive, dbg_enable, host_low, got_stb, line;
   logic [8:0]  got, d;
   logic [15:0] m;
   logic [15:0] exp_q[$], msk_q[$];
   logic [8:0]  tx_q[$];
   int          fail_count = 0;
   int          comparisons = 0;
   integer      seed = 32'hebce;
   assign line = (pin_oe ? pin_o : 1'b1) & !host_low;
   always #20 clock = ~clock;
   dswp_serial_port uut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_i(line), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_hi_drive(pin_hi_drive), .dbg_enable(dbg_enable));
   dswp_host host (.clock(clock), .line(line), .drive_low(host_low), .got(got), .got_stb(got_stb));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   // read with expected value under a mask, noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [15:0] mk, input logic [15:0] ex);
      exp_q.push_back(ex);
      msk_q.push_back(mk);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   // monitor: compare read data and host characters against the oldest note
   always @(posedge clock) begin
      rd_q <= reg_rd;
      if (rd_q) begin
         m = msk_q.pop_front();
         check("reg_rdata", reg_rdata & m, exp_q.pop_front());
      end
      if (got_stb) check("host_char", {7'h00, got}, {7'h00, tx_q.pop_front()});
   end
   // watchdog
   initial begin
      repeat (30000) @(posedge clock);
      fail_count++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      rd(REG_CTRL, 16'hffff, 16'h0101);
      rd(REG_RELOAD, 16'hffff, 16'h0040);
      rd(8'h09, 16'hffff, 16'h0000);
      // autobaud on both characters
      host.bitp = 16;
      host.send(9'h080, 1'b1, 16);
      repeat (8) @(posedge clock);
      rd(REG_RELOAD, 16'hffff, 16'h0080);
      rd(REG_CTRL, 16'h0101, 16'h0001);
      wr(REG_CTRL, 16'h0104);
      rd(REG_CTRL, 16'h0001, 16'h0000);
      host.send(9'h00d, 1'b1, 16);
      repeat (8) @(posedge clock);
      rd(REG_RELOAD, 16'hffff, 16'd128);
      // enabled: upper reload bits ignored, bit period 8
      wr(REG_CTRL, 16'h0001);
      wr(REG_RELOAD, 16'h1040);
      host.bitp = 8;
      // transmit in each drive mode, the last one nine-bit with strong driver
      for (int i = 0; i < 4; i++) begin
         wr(REG_CTRL, 16'h0001 | (16'(i) << 3) | ((i == 3) ? 16'h0060 : 16'h0000));
         host.nbits = (i == 3) ? 9 : 8;
         d = 9'($random(seed));
         if (i < 3) d[8] = 1'b0;
         tx_q.push_back(d);
         wr(REG_TXDATA, {7'h00, d});
         repeat (110) @(posedge clock);
      end
      // receive: nine-bit, then a char with short stop directly followed by another
      wr(REG_RELOAD, 16'h0080);
      host.bitp = 16;
      for (int j = 0; j < 2; j++) begin
         d = 9'($random(seed));
         if (j == 1) begin
            wr(REG_CTRL, 16'h0001);
            host.nbits = 8;
            d[8] = 1'b0;
            host.send(~d, 1'b1, 13);
         end
         host.send(d, 1'b1, 16);
         repeat (8) @(posedge clock);
         rd(REG_STATUS, 16'h000c, 16'h0004);
         rd(REG_RXDATA, 16'h01ff, {7'h00, d});
      end
      // false start is dropped
      host.glitch();
      repeat (30) @(posedge clock);
      rd(REG_STATUS, 16'h0006, 16'h0000);
      // low stop bit gives a framing error, cleared by writing one
      host.send(9'($random(seed)) & 9'h0ff, 1'b0, 16);
      repeat (8) @(posedge clock);
      rd(REG_STATUS, 16'h0008, 16'h0008);
      wr(REG_STATUS, 16'h0008);
      rd(REG_STATUS, 16'h0008, 16'h0000);
      // flow control: data waits for the host start bit
      wr(REG_CTRL, 16'h0081);
      wr(REG_TXDATA, 16'h005a);
      repeat (40) @(posedge clock);
      rd(REG_STATUS, 16'h0001, 16'h0001);
      host.send(9'h0ff, 1'b1, 16);
      repeat (20) @(posedge clock);
      rd(REG_STATUS, 16'h0001, 16'h0000);
      // lock then try to disable
      wr(REG_CTRL, 16'h0003);
      wr(REG_CTRL, 16'h0000);
      rd(REG_CTRL, 16'h0003, 16'h0003);
      repeat (4) @(posedge clock);
      results();
   end
endmodule : dswp_serial_port_tb
